// file: core/mpt_defs.vh
`ifndef MPT_DEFS_VH
`define MPT_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MPT_A_CTRL 8'h00
`define MPT_A_FLC 8'h04
`define MPT_A_CTPRI 8'h08
`define MPT_A_GFTRIP 8'h0c
`define MPT_A_GFALARM 8'h10
`define MPT_A_GFDLY 8'h14
`define MPT_A_UC 8'h18
`define MPT_A_JAM 8'h1c
`define MPT_A_SC 8'h20
`define MPT_A_OVL 8'h24
`define MPT_A_LATCH 8'h28
`define MPT_A_STATUS 8'h2c
`define MPT_A_MAXT 8'h30
`define MPT_A_RTD_HI 3'h2
`define MPT_RTD_CNT 6

// ----------------------------------------
// field positions
// ----------------------------------------
`define MPT_CTRL_CLR 0
`define MPT_CTRL_MISS 1
`define MPT_LT_GFT 0
`define MPT_LT_GFA 1
`define MPT_LT_UC 2
`define MPT_LT_JAM 3
`define MPT_LT_SC 4
`define MPT_LT_RTDT 5
`define MPT_LT_RTDA 6

// ----------------------------------------
// scaling and limits
// ----------------------------------------
`define MPT_PCT 32'd100
`define MPT_STOP_PCT 32'd5
`define MPT_GF_2000 32'd2000
`define MPT_GF_STEP 32'd10
`define MPT_RTD_HYST 9'h004
`define MPT_GF_DMAX 11'd200
`define MPT_SC_DMAX 11'd205
`define MPT_JAM_DMIN 11'd5
`define MPT_JAM_DMAX 11'd1250

// ----------------------------------------
// timing: delays count tenths of a second
// ----------------------------------------
`define MPT_CLK_HZ 100000000
`define MPT_TENTHS_PER_S 10

`endif

// file: core/mpt_trip.v
// Overview of operation
// RQ1: ground CT ratio 2000:1 or 50..250:5
// RQ2: ground trip and alarm, own delays
// RQ3: ground trip delay zero to 20.0 s
// RQ4: undercurrent persisting past delay raises alarm
// RQ5: undercurrent OFF disables it, delay ignored
// RQ6: unlatched undercurrent drops when current recovers
// RQ7: undercurrent clears at stop unless latched
// RQ8: jam armed only after start, while running
// RQ9: jam 150..450 percent, 0.5..125.0 s
// RQ10: jam OFF disables it, delay ignored
// RQ11: short circuit always active unless OFF
// RQ12: short circuit 4..12 FULL_LOAD_CURRENT, up to 20.5 s
// RQ13: overload alarm 1.01..1.50 FULL_LOAD_CURRENT, no delay
// RQ14: overload alarm never latches
// RQ15: six stator channels, count selects lowest
// RQ16: per channel trip and alarm thresholds
// RQ17: hottest counted channel forwarded only
// RQ18: open channel flagged and excluded everywhere
// RQ19: missing sensor enable makes open alarm
// RQ20: reset blocked until 4 C below threshold
// RQ21: stop below 5 percent CT primary
// RQ22: running once current falls below FULL_LOAD_CURRENT
// RQ23: timers count while condition holds continuously
// RQ24: zero threshold means OFF, timer held
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defs.vh"

module mpt_ptimer (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire tick,
    input wire cond,
    input wire [10:0] delay,
    output wire fire
);
    reg [10:0] cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 11'h000;
        end else if (clk_en) begin
            if (!cond) begin
                cnt_q <= 11'h000; // RQ23
            end else if (tick && cnt_q < delay) begin
                cnt_q <= cnt_q + 11'h001; // RQ23
            end
        end
    end

    // zero delay fires in the same cycle the condition appears
    assign fire = cond && (cnt_q >= delay); // RQ23
endmodule

module mpt_trip #(
    parameter TENTH_CYCLES = `MPT_CLK_HZ / `MPT_TENTHS_PER_S
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] avg_current,
    input wire [15:0] max_phase_current,
    input wire [11:0] gf_secondary_ma,
    input wire [47:0] rtd_temp,
    input wire [5:0] rtd_open,
    output wire gf_trip,
    output wire gf_alarm,
    output wire uc_alarm,
    output wire jam_trip,
    output wire sc_trip,
    output wire ovl_alarm,
    output wire rtd_trip,
    output wire rtd_alarm,
    output wire sensor_alarm,
    output wire [5:0] open_sensor_indication,
    output wire [7:0] stator_max_temp,
    output wire motor_running
);
    localparam ST_STOP = 3'b001;
    localparam ST_START = 3'b010;
    localparam ST_RUN = 3'b100;

    // ----------------------------------------
    // setpoint registers
    // ----------------------------------------
    reg miss_en_q;
    reg [2:0] gf_ratio_q;
    reg [2:0] stator_sensor_count_q;
    reg [15:0] full_load_current_q;
    reg [15:0] ct_primary_q;
    reg [23:0] gf_trip_thr_q;
    reg [23:0] gf_alarm_thr_q;
    reg [7:0] gf_trip_dly_q;
    reg [7:0] gf_alarm_dly_q;
    reg [15:0] uc_thr_q;
    reg [7:0] uc_dly_q;
    reg [8:0] jam_threshold_q;
    reg [10:0] jam_dly_q;
    reg [3:0] sc_mult_q;
    reg [7:0] sc_dly_q;
    reg [7:0] ovl_pct_q;
    reg [6:0] output_latch_selection_q;
    reg [15:0] rtd_thr_q [0:5];
    reg clr_q;
    reg [31:0] prdata_q;
    reg setup_q;
    reg [31:0] rd_d;
    reg hit_d;
    integer i;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // read data is captured in the setup cycle so prdata is a flop
    wire acc = psel && penable;
    wire wr = acc && pwrite && pready;
    wire [2:0] ridx = paddr[4:2];
    wire rtd_hit = (paddr[7:5] == `MPT_A_RTD_HI) && (paddr[1:0] == 2'h0)
        && (ridx < `MPT_RTD_CNT);
    assign pready = setup_q && clk_en;
    assign prdata = prdata_q;
    assign pslverr = acc && pready && !hit_d;

    always @* begin
        hit_d = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            `MPT_A_CTRL: rd_d = {24'h0, stator_sensor_count_q, gf_ratio_q, miss_en_q, 1'b0};
            `MPT_A_FLC: rd_d = {16'h0, full_load_current_q};
            `MPT_A_CTPRI: rd_d = {16'h0, ct_primary_q};
            `MPT_A_GFTRIP: rd_d = {8'h0, gf_trip_thr_q};
            `MPT_A_GFALARM: rd_d = {8'h0, gf_alarm_thr_q};
            `MPT_A_GFDLY: rd_d = {16'h0, gf_alarm_dly_q, gf_trip_dly_q};
            `MPT_A_UC: rd_d = {8'h0, uc_dly_q, uc_thr_q};
            `MPT_A_JAM: rd_d = {5'h0, jam_dly_q, 7'h0, jam_threshold_q};
            `MPT_A_SC: rd_d = {16'h0, sc_dly_q, 4'h0, sc_mult_q};
            `MPT_A_OVL: rd_d = {24'h0, ovl_pct_q};
            `MPT_A_LATCH: rd_d = {25'h0, output_latch_selection_q};
            `MPT_A_STATUS: rd_d = {16'h0, motor_running, open_sensor_indication,
                sensor_alarm, rtd_alarm, rtd_trip, ovl_alarm, sc_trip, jam_trip,
                uc_alarm, gf_alarm, gf_trip};
            `MPT_A_MAXT: rd_d = {24'h0, stator_max_temp};
            default: begin
                if (rtd_hit) begin
                    rd_d = {16'h0, rtd_thr_q[ridx]};
                end else begin
                    hit_d = 1'b0;
                end
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            clr_q <= 1'b0;
            miss_en_q <= 1'b0;
            gf_ratio_q <= 3'h0;
            stator_sensor_count_q <= 3'h0;
            full_load_current_q <= 16'h0000;
            ct_primary_q <= 16'h0000;
            gf_trip_thr_q <= 24'h00_0000;
            gf_alarm_thr_q <= 24'h00_0000;
            gf_trip_dly_q <= 8'h00;
            gf_alarm_dly_q <= 8'h00;
            uc_thr_q <= 16'h0000;
            uc_dly_q <= 8'h00;
            jam_threshold_q <= 9'h000;
            jam_dly_q <= 11'h000;
            sc_mult_q <= 4'h0;
            sc_dly_q <= 8'h00;
            ovl_pct_q <= 8'h00;
            output_latch_selection_q <= 7'h00;
            for (i = 0; i < `MPT_RTD_CNT; i = i + 1) begin
                rtd_thr_q[i] <= 16'h0000;
            end
        end else if (clk_en) begin
            clr_q <= 1'b0;
            if (psel && !penable) begin
                setup_q <= 1'b1;
                prdata_q <= rd_d;
            end else if (acc) begin
                setup_q <= 1'b0;
            end
            if (wr) begin
                case (paddr)
                    `MPT_A_CTRL: begin
                        clr_q <= pwdata[`MPT_CTRL_CLR];
                        miss_en_q <= pwdata[`MPT_CTRL_MISS];
                        gf_ratio_q <= pwdata[4:2]; // RQ1
                        stator_sensor_count_q <= pwdata[7:5]; // RQ15
                    end
                    `MPT_A_FLC: full_load_current_q <= pwdata[15:0];
                    `MPT_A_CTPRI: ct_primary_q <= pwdata[15:0];
                    `MPT_A_GFTRIP: gf_trip_thr_q <= pwdata[23:0];
                    `MPT_A_GFALARM: gf_alarm_thr_q <= pwdata[23:0];
                    `MPT_A_GFDLY: begin
                        gf_trip_dly_q <= pwdata[7:0];
                        gf_alarm_dly_q <= pwdata[15:8];
                    end
                    `MPT_A_UC: begin
                        uc_thr_q <= pwdata[15:0];
                        uc_dly_q <= pwdata[23:16];
                    end
                    `MPT_A_JAM: begin
                        jam_threshold_q <= pwdata[8:0];
                        jam_dly_q <= pwdata[26:16];
                    end
                    `MPT_A_SC: begin
                        sc_mult_q <= pwdata[3:0];
                        sc_dly_q <= pwdata[15:8];
                    end
                    `MPT_A_OVL: ovl_pct_q <= pwdata[7:0];
                    `MPT_A_LATCH: output_latch_selection_q <= pwdata[6:0];
                    default: begin
                        if (rtd_hit) begin
                            rtd_thr_q[ridx] <= pwdata[15:0]; // RQ16
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // tenth-second tick
    // ----------------------------------------
    reg [23:0] pre_q;
    wire tick = (pre_q == TENTH_CYCLES - 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 24'h00_0000;
        end else if (clk_en) begin
            pre_q <= tick ? 24'h00_0000 : pre_q + 24'h00_0001;
        end
    end

    // ----------------------------------------
    // motor state
    // ----------------------------------------
    wire [31:0] full_load_current = {16'h0, full_load_current_q};
    wire [31:0] avg = {16'h0, avg_current};
    wire [31:0] avg_pct = avg * `MPT_PCT;
    wire stop_c = avg_pct < {16'h0, ct_primary_q} * `MPT_STOP_PCT; // RQ21
    reg [2:0] st_q;
    wire stopped = st_q[0];
    wire running = st_q[2];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_STOP;
        end else if (clk_en) begin
            case (st_q)
                ST_STOP: if (avg > full_load_current) st_q <= ST_START;
                ST_START: begin
                    if (stop_c) st_q <= ST_STOP; // RQ21
                    else if (avg < full_load_current) st_q <= ST_RUN; // RQ22
                end
                ST_RUN: if (stop_c) st_q <= ST_STOP; // RQ21
                default: st_q <= ST_STOP;
            endcase
        end
    end

    // ----------------------------------------
    // current functions
    // ----------------------------------------
    wire [31:0] gf_sec = {20'h0, gf_secondary_ma};
    // primary milliamps; ratio code 0 picks the 2000:1 sensor
    wire [31:0] gf_pri = (gf_ratio_q == 3'h0) ? gf_sec * `MPT_GF_2000 // RQ1
        : gf_sec * `MPT_GF_STEP * {29'h0, gf_ratio_q}; // RQ1
    wire gft_c = (gf_trip_thr_q != 24'h0) && (gf_pri > {8'h0, gf_trip_thr_q}); // RQ2 RQ24
    wire gfa_c = (gf_alarm_thr_q != 24'h0) && (gf_pri > {8'h0, gf_alarm_thr_q}); // RQ2 RQ24
    wire uc_c = (uc_thr_q != 16'h0) && !stopped && (avg_current < uc_thr_q); // RQ4 RQ5 RQ7
    wire jam_c = (jam_threshold_q != 9'h0) && running // RQ8 RQ10
        && (avg_pct > full_load_current * {23'h0, jam_threshold_q}); // RQ9
    wire sc_c = (sc_mult_q != 4'h0) // RQ11
        && ({16'h0, max_phase_current} > full_load_current * {28'h0, sc_mult_q}); // RQ12
    wire ovl_c = (ovl_pct_q != 8'h0) && (avg_pct > full_load_current * {24'h0, ovl_pct_q}); // RQ13

    // delays beyond the documented ranges are clamped, not rejected
    wire [10:0] gft_dly = ({3'h0, gf_trip_dly_q} > `MPT_GF_DMAX) ? `MPT_GF_DMAX
        : {3'h0, gf_trip_dly_q}; // RQ3
    wire [10:0] sc_dly = ({3'h0, sc_dly_q} > `MPT_SC_DMAX) ? `MPT_SC_DMAX
        : {3'h0, sc_dly_q}; // RQ12
    wire [10:0] jam_dly = (jam_dly_q < `MPT_JAM_DMIN) ? `MPT_JAM_DMIN
        : (jam_dly_q > `MPT_JAM_DMAX) ? `MPT_JAM_DMAX : jam_dly_q; // RQ9

    wire [4:0] fire;
    wire [4:0] cond = {sc_c, jam_c, uc_c, gfa_c, gft_c};
    wire [54:0] dly = {sc_dly, jam_dly, {3'h0, uc_dly_q}, {3'h0, gf_alarm_dly_q}, gft_dly};

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : tmr
            mpt_ptimer u_tmr (
                .pclk(pclk),
                .presetn(presetn),
                .clk_en(clk_en),
                .tick(tick),
                .cond(cond[g]),
                .delay(dly[11*g +: 11]),
                .fire(fire[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // stator sensors
    // ----------------------------------------
    reg [5:0] rt_q;
    reg [5:0] ra_q;
    reg [5:0] rt_d;
    reg [5:0] ra_d;
    reg [7:0] maxt_d;
    reg miss_d;
    reg use_c;
    reg [7:0] t;
    reg [7:0] thr_t;
    reg [7:0] thr_a;
    integer j;

    always @* begin
        rt_d = 6'h00;
        ra_d = 6'h00;
        maxt_d = 8'h00;
        miss_d = 1'b0;
        use_c = 1'b0;
        t = 8'h00;
        thr_t = 8'h00;
        thr_a = 8'h00;
        for (j = 0; j < `MPT_RTD_CNT; j = j + 1) begin
            t = rtd_temp[8*j +: 8];
            thr_a = rtd_thr_q[j][7:0];
            thr_t = rtd_thr_q[j][15:8];
            use_c = (j < stator_sensor_count_q) && !rtd_open[j]; // RQ15 RQ18
            if (j < stator_sensor_count_q && rtd_open[j]) miss_d = 1'b1; // RQ19
            if (use_c && t > maxt_d) maxt_d = t; // RQ17
            // cooling band: output stays until 4 C under the exceeded level
            rt_d[j] = (use_c && thr_t != 8'h0 && t > thr_t) // RQ16
                || (rt_q[j] && !((!use_c || {1'b0, t} + `MPT_RTD_HYST <= {1'b0, thr_t})
                && (!output_latch_selection_q[`MPT_LT_RTDT] || clr_q))); // RQ20
            ra_d[j] = (use_c && thr_a != 8'h0 && t > thr_a) // RQ16
                || (ra_q[j] && !((!use_c || {1'b0, t} + `MPT_RTD_HYST <= {1'b0, thr_a})
                && (!output_latch_selection_q[`MPT_LT_RTDA] || clr_q))); // RQ20
        end
    end

    // ----------------------------------------
    // output flags
    // ----------------------------------------
    // a new activation in the clear cycle wins over the clear
    reg [4:0] out_q;
    reg ovl_q;
    reg miss_q;
    reg [7:0] maxt_q;
    reg [5:0] open_q;
    wire [4:0] lt = output_latch_selection_q[4:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 5'h00;
            ovl_q <= 1'b0;
            miss_q <= 1'b0;
            maxt_q <= 8'h00;
            open_q <= 6'h00;
            rt_q <= 6'h00;
            ra_q <= 6'h00;
        end else if (clk_en) begin
            out_q <= fire | (out_q & lt & {5{!clr_q}}); // RQ2 RQ4 RQ6 RQ7
            ovl_q <= ovl_c; // RQ13 RQ14
            miss_q <= miss_en_q && miss_d; // RQ19
            maxt_q <= maxt_d; // RQ17
            open_q <= rtd_open; // RQ18
            rt_q <= rt_d;
            ra_q <= ra_d;
        end
    end

    assign gf_trip = out_q[`MPT_LT_GFT];
    assign gf_alarm = out_q[`MPT_LT_GFA];
    assign uc_alarm = out_q[`MPT_LT_UC];
    assign jam_trip = out_q[`MPT_LT_JAM];
    assign sc_trip = out_q[`MPT_LT_SC];
    assign ovl_alarm = ovl_q;
    assign rtd_trip = |rt_q;
    assign rtd_alarm = |ra_q;
    assign sensor_alarm = miss_q;
    assign open_sensor_indication = open_q;
    assign stator_max_temp = maxt_q;
    assign motor_running = running;
endmodule

`default_nettype wire

// file: test/mpt_trip_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mpt_trip_props #(
    parameter TENTH_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [15:0] avg_current,
    input wire logic [15:0] max_phase_current,
    input wire logic [11:0] gf_secondary_ma,
    input wire logic [47:0] rtd_temp,
    input wire logic [5:0] rtd_open,
    input wire logic gf_trip,
    input wire logic gf_alarm,
    input wire logic jam_trip,
    input wire logic sc_trip,
    input wire logic ovl_alarm,
    input wire logic sensor_alarm,
    input wire logic [5:0] open_sensor_indication,
    input wire logic [7:0] stator_max_temp,
    input wire logic motor_running
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // hottest healthy channel is an upper bound for any counted subset
    function automatic logic [7:0] hot(input logic [47:0] t, input logic [5:0] o);
        integer i;
        hot = 8'h00;
        for (i = 0; i < 6; i = i + 1) begin
            if (!o[i] && t[8*i +: 8] > hot) begin
                hot = t[8*i +: 8];
            end
        end
    endfunction

    sequence setup_s;
        psel && !penable && clk_en;
    endsequence

    apb_ready_a: assert property (setup_s ##1 clk_en |-> pready)
        else $error("no ready in access cycle");
    err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    open_flag_a: assert property (clk_en |=> open_sensor_indication == $past(rtd_open))
        else $error("open flags wrong");
    max_bound_a: assert property (clk_en |=>
        stator_max_temp <= hot($past(rtd_temp), $past(rtd_open)))
        else $error("max temp too high");
    sensor_src_a: assert property ($rose(sensor_alarm) |-> $past(rtd_open) != 6'h00)
        else $error("sensor alarm without open");
    jam_run_a: assert property ($rose(jam_trip) |-> $past(motor_running))
        else $error("jam while not running");
    gf_cause_a: assert property ($rose(gf_trip) || $rose(gf_alarm) |->
        $past(gf_secondary_ma) != 12'h000)
        else $error("ground output without current");
    sc_cause_a: assert property ($rose(sc_trip) |-> $past(max_phase_current) != 16'h0)
        else $error("short circuit without current");
    ovl_cause_a: assert property ($rose(ovl_alarm) |-> $past(avg_current) != 16'h0)
        else $error("overload without current");
endmodule

bind mpt_trip mpt_trip_props #(.TENTH_CYCLES(TENTH_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .avg_current(avg_current),
    .max_phase_current(max_phase_current), .gf_secondary_ma(gf_secondary_ma),
    .rtd_temp(rtd_temp), .rtd_open(rtd_open), .gf_trip(gf_trip), .gf_alarm(gf_alarm),
    .jam_trip(jam_trip), .sc_trip(sc_trip), .ovl_alarm(ovl_alarm),
    .sensor_alarm(sensor_alarm), .open_sensor_indication(open_sensor_indication),
    .stator_max_temp(stator_max_temp), .motor_running(motor_running)
);
`default_nettype wire

// file: test/mpt_plant.sv
`timescale 1ns/1ps
`default_nettype none
// current transformers and stator sensors, updated just after an edge
module mpt_plant (
    input wire logic pclk,
    output var logic [15:0] avg_current,
    output var logic [15:0] max_phase_current,
    output var logic [11:0] gf_secondary_ma,
    output var logic [47:0] rtd_temp,
    output var logic [5:0] rtd_open
);
    initial begin
        avg_current = 16'h0;
        max_phase_current = 16'h0;
        gf_secondary_ma = 12'h0;
        rtd_temp = 48'h0;
        rtd_open = 6'h00;
    end
    task set_i(input logic [15:0] a);
        @(posedge pclk);
        avg_current <= a;
        max_phase_current <= a;
    endtask
    task set_g(input logic [11:0] g);
        @(posedge pclk);
        gf_secondary_ma <= g;
    endtask
    task set_t(input logic [47:0] t, input logic [5:0] o);
        @(posedge pclk);
        rtd_temp <= t;
        rtd_open <= o;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, gf_trip, gf_alarm, uc_alarm, jam_trip, sc_trip, ovl_alarm;
    wire rtd_trip, rtd_alarm, sensor_alarm, motor_running;
    wire [15:0] avg_current, max_phase_current;
    wire [11:0] gf_secondary_ma;
    wire [47:0] rtd_temp;
    wire [5:0] rtd_open, osi;
    wire [7:0] maxt;
    integer fail_count = 0;
    integer checks = 0;
    logic [31:0] q;
    logic e;

    always #5 pclk = ~pclk;

    mpt_trip #(.TENTH_CYCLES(10)) dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .avg_current(avg_current), .max_phase_current(max_phase_current),
        .gf_secondary_ma(gf_secondary_ma), .rtd_temp(rtd_temp), .rtd_open(rtd_open),
        .gf_trip(gf_trip), .gf_alarm(gf_alarm), .uc_alarm(uc_alarm), .jam_trip(jam_trip),
        .sc_trip(sc_trip), .ovl_alarm(ovl_alarm), .rtd_trip(rtd_trip), .rtd_alarm(rtd_alarm),
        .sensor_alarm(sensor_alarm), .open_sensor_indication(osi), .stator_max_temp(maxt),
        .motor_running(motor_running)
    );
    mpt_plant plant (
        .pclk(pclk), .avg_current(avg_current), .max_phase_current(max_phase_current),
        .gf_secondary_ma(gf_secondary_ma), .rtd_temp(rtd_temp), .rtd_open(rtd_open)
    );

    // ----------------------------------------
    // apb master
    // ----------------------------------------
    // pready and read data are taken at the completing rising edge, then released
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        `CHK("pready", 1'b1, pready)
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        `CHK("read", x, q)
    endtask
    task wt(input integer n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task run;
        plant.set_i(16'd150);
        wt(3);
        plant.set_i(16'd80);
        wt(3);
    endtask
    task stop_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        stop_test;
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`MPT_A_FLC, 32'h0);
        wr(`MPT_A_STATUS, 32'hffff);
        rdc(`MPT_A_STATUS, 32'h0);
        xfer(1'b0, 8'h34, 32'h0);
        `CHK("err", 1'b1, e)
        `CHK("errdata", 32'h0, q)
        wr(`MPT_A_CTRL, 32'h62);
        wr(`MPT_A_FLC, 32'd100);
        wr(`MPT_A_CTPRI, 32'd1000);
        rdc(`MPT_A_FLC, 32'd100);
        wr(`MPT_A_SC, 32'h4);
        plant.set_i(16'd400);
        wt(3);
        `CHK("sc", 1'b0, sc_trip)
        plant.set_i(16'd401);
        wt(2);
        `CHK("sc", 1'b1, sc_trip)
        wr(`MPT_A_JAM, 32'd150);
        plant.set_i(16'd200);
        wt(60);
        `CHK("jam", 1'b0, jam_trip)
        plant.set_i(16'd80);
        wt(2);
        `CHK("run", 1'b1, motor_running)
        wr(`MPT_A_UC, 32'd90 | (32'd2 << 16));
        wt(8);
        `CHK("uc", 1'b0, uc_alarm)
        wt(15);
        `CHK("uc", 1'b1, uc_alarm)
        plant.set_i(16'd95);
        wt(2);
        `CHK("uc", 1'b0, uc_alarm)
        plant.set_i(16'd160);
        wt(38);
        `CHK("jam", 1'b0, jam_trip)
        wt(16);
        `CHK("jam", 1'b1, jam_trip)
        wr(`MPT_A_JAM, 32'h0);
        wt(2);
        `CHK("jam", 1'b0, jam_trip)
        wr(`MPT_A_LATCH, 32'h7f);
        wr(`MPT_A_OVL, 32'd101);
        plant.set_i(16'd102);
        wt(2);
        `CHK("ovl", 1'b1, ovl_alarm)
        plant.set_i(16'd101);
        wt(2);
        `CHK("ovl", 1'b0, ovl_alarm)
        plant.set_i(16'd80);
        wt(25);
        plant.set_i(16'd0);
        wt(3);
        `CHK("run", 1'b0, motor_running)
        `CHK("uc", 1'b1, uc_alarm)
        wr(`MPT_A_CTRL, 32'h63);
        wt(2);
        `CHK("uc", 1'b0, uc_alarm)
        wr(`MPT_A_LATCH, 32'h0);
        run;
        wt(25);
        `CHK("uc", 1'b1, uc_alarm)
        plant.set_i(16'd0);
        wt(3);
        `CHK("uc", 1'b0, uc_alarm)
        wr(`MPT_A_UC, 32'd2 << 16);
        run;
        wt(40);
        `CHK("uc", 1'b0, uc_alarm)
        plant.set_i(16'd0);
        wr(`MPT_A_GFTRIP, 32'd4000);
        wr(`MPT_A_GFALARM, 32'd1000);
        wr(`MPT_A_GFDLY, 32'h300);
        plant.set_g(12'd2);
        wt(18);
        `CHK("gft", 1'b0, gf_trip)
        `CHK("gfa", 1'b0, gf_alarm)
        wt(15);
        `CHK("gfa", 1'b1, gf_alarm)
        plant.set_g(12'd3);
        wt(2);
        `CHK("gft", 1'b1, gf_trip)
        plant.set_g(12'd0);
        wr(`MPT_A_CTRL, 32'h66);
        plant.set_g(12'd400);
        wt(3);
        `CHK("gft", 1'b0, gf_trip)
        plant.set_g(12'd401);
        wt(2);
        `CHK("gft", 1'b1, gf_trip)
        plant.set_g(12'd0);
        wr(`MPT_A_GFDLY, 32'hff);
        plant.set_g(12'd401);
        wt(1985);
        `CHK("gft", 1'b0, gf_trip)
        wt(20);
        `CHK("gft", 1'b1, gf_trip)
        plant.set_g(12'd0);
        wr(8'h40, 32'h645a);
        wr(8'h44, 32'h6400);
        plant.set_t(48'h00c80000fa65, 6'h02);
        wt(3);
        `CHK("rtdt", 1'b1, rtd_trip)
        `CHK("maxt", 8'h65, maxt)
        `CHK("osi", 6'h02, osi)
        `CHK("miss", 1'b1, sensor_alarm)
        rdc(`MPT_A_STATUS, 32'h5c0);
        rdc(`MPT_A_MAXT, 32'h65);
        plant.set_t(48'h00c80000fa61, 6'h02);
        wt(3);
        `CHK("rtdt", 1'b1, rtd_trip)
        plant.set_t(48'h00c80000fa60, 6'h02);
        wt(3);
        `CHK("rtdt", 1'b0, rtd_trip)
        `CHK("rtda", 1'b1, rtd_alarm)
        plant.set_t(48'h00c80000fa56, 6'h02);
        wt(3);
        `CHK("rtda", 1'b0, rtd_alarm)
        @(posedge pclk);
        clk_en <= 1'b0;
        plant.set_t(48'h00c80000fa65, 6'h02);
        wt(3);
        `CHK("rtdt", 1'b0, rtd_trip)
        `CHK("maxt", 8'h56, maxt)
        @(posedge pclk);
        clk_en <= 1'b1;
        wt(2);
        `CHK("rtdt", 1'b1, rtd_trip)
        `CHK("maxt", 8'h65, maxt)
        stop_test;
    end
endmodule
`default_nettype wire
